//--- include/ctrl_marks_pkg.sv
// package: register map, field layout, reset values and timing of the control-mark block
package ctrl_marks_pkg;
   localparam int unsigned num_chan = 4;
   localparam int unsigned num_axis = 8;
   localparam int unsigned num_panel = 8;
   localparam int unsigned num_sensor = 20;
   // register byte offsets
   localparam logic [7:0] reg_chan_marks = 8'h00; // per channel: bits[4c+3:4c]
   localparam logic [7:0] reg_general = 8'h04;
   localparam logic [7:0] reg_panel_kbd = 8'h08; // [7:0] panel, [15:8] keyboard
   localparam logic [7:0] reg_sensor = 8'h0c;
   localparam logic [7:0] reg_axis_disp = 8'h10; // displayed axes mask
   localparam logic [7:0] reg_events = 8'h14; // write 1: command launch per channel [3:0] / probing / scan
   localparam logic [7:0] reg_status = 8'h18;
   localparam logic [7:0] reg_chan_status = 8'h1c;
   // per-channel field positions within a nibble
   localparam int unsigned f_opt_stop = 0;
   localparam int unsigned f_rapid = 1;
   localparam int unsigned f_wait_cancel = 2;
   localparam int unsigned f_ovr_full = 3;
   // general register fields
   localparam int unsigned f_running = 0;
   localparam int unsigned f_probe1_en = 1;
   localparam int unsigned f_probe2_en = 2;
   localparam int unsigned f_probe1_mon = 3;
   localparam int unsigned f_probe2_mon = 4;
   localparam int unsigned f_sup1_en = 5;
   localparam int unsigned f_sup1_start = 6;
   localparam int unsigned f_sup2_en = 7;
   localparam int unsigned f_sup2_start = 8;
   localparam int unsigned f_jog_hw = 9; // jog mode with handwheel selector
   localparam int unsigned f_axis_adv = 10;
   localparam int unsigned f_probe_sel = 11; // 0 probe one, 1 probe two
   localparam int unsigned f_reset = 12; // write 1: control reset
   localparam int unsigned f_abort_base = 16; // command abort [19:16]
   localparam int unsigned f_prg_abort_base = 20; // program abort [23:20]
   localparam int unsigned f_abort_label_base = 24; // abort label active [27:24]
   // event register fields
   localparam int unsigned e_launch_base = 0;  // [3:0]
   localparam int unsigned e_probe_cmd = 4;
   localparam int unsigned e_scan = 5;
   // reset values
   localparam logic [31:0] general_rst = 32'h0000_0006; // probe enables default to one
   localparam logic [31:0] zero_rst = 32'h0000_0000;
   // timing
   localparam int unsigned clk_mhz = 200;
   localparam int unsigned charge_time_us = 100;
   localparam int unsigned charge_cycles = charge_time_us * clk_mhz;
   localparam int unsigned kbd_delay_ms = 2;
   localparam int unsigned kbd_delay_cycles = kbd_delay_ms * 1000 * clk_mhz;
   localparam logic [1:0] resp_okay = 2'b00;
   localparam logic [1:0] resp_slverr = 2'b10;

   // two bits are enough and keep the status word packing exact
   typedef enum logic [1:0] {sup_off, sup_charge, sup_on} sup_state_t;

   typedef struct packed {
      logic [num_chan-1:0] opt_stop_honour;
      logic [num_chan-1:0] jog_rapid;
      logic [num_chan-1:0] wait_release;
      logic [num_chan-1:0] override_full;
      logic [num_chan-1:0] chan_free;
      logic [num_chan-1:0] cmd_aborted;
      logic [num_chan-1:0] prg_restart;
   } chan_out_t;

   typedef struct packed {
      logic motion_enable;
      logic logic_stop_error;
      logic probing_error;
      logic probe_one_safe;
      logic probe_two_safe;
      logic supply_one_on;
      logic supply_one_contactor;
      logic supply_two_on;
      logic supply_two_contactor;
   } gen_out_t;
endpackage : ctrl_marks_pkg

//--- hdl/ctrl_marks.sv
// control-mark decoder between the machine logic controller and the numerical controller
`timescale 1ns/1ps
module ctrl_marks #(
   parameter int unsigned charge_cycles = ctrl_marks_pkg::charge_cycles,
   parameter int unsigned kbd_delay_cycles = ctrl_marks_pkg::kbd_delay_cycles
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // decoded controls toward the controller core
   output ctrl_marks_pkg::chan_out_t chan_out,
   output ctrl_marks_pkg::gen_out_t gen_out,
   output logic [ctrl_marks_pkg::num_axis-1:0] handwheel_axis,
   output logic [ctrl_marks_pkg::num_panel-1:0] panel_off,
   output logic [ctrl_marks_pkg::num_panel-1:0] keyboard_off,
   output logic [ctrl_marks_pkg::num_sensor-1:0] sensor_off
);
   localparam int unsigned nc = ctrl_marks_pkg::num_chan;
   localparam int unsigned na = ctrl_marks_pkg::num_axis;

   typedef struct packed {
      logic aw_full;
      logic [7:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] chan_marks;
      logic [31:0] general;
      logic [15:0] panel_kbd;
      logic [19:0] sensor;
      logic [na-1:0] axis_disp;
      logic [nc-1:0] cmd_busy;
      logic [nc-1:0] chan_free;
      logic [nc-1:0] cmd_aborted;
      logic [nc-1:0] prg_restart;
      logic [nc-1:0] prg_abort_prev;
      logic adv_prev;
      logic jog_hw_prev;
      logic running_prev;
      logic logic_stop_error;
      logic probing_error;
      logic [na-1:0] hw_axis;
      ctrl_marks_pkg::sup_state_t sup1;
      ctrl_marks_pkg::sup_state_t sup2;
      logic [31:0] cnt1;
      logic [31:0] cnt2;
      logic [7:0] kbd_applied;
      logic [31:0] kbd_cnt;
      ctrl_marks_pkg::chan_out_t chan_out;
      ctrl_marks_pkg::gen_out_t gen_out;
   } state_t;

   state_t st;
   state_t next_st;

   // lowest set bit of a mask as a one-hot word, zero if none
   function automatic logic [na-1:0] first_of(input logic [na-1:0] m);
      logic [na-1:0] r;
      r = '0;
      for (int i = na - 1; i >= 0; i--) begin
         if (m[i]) begin
            r = '0;
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction : first_of

   // next displayed axis after the current one, wrapping to the first
   function automatic logic [na-1:0] next_axis(input logic [na-1:0] cur, input logic [na-1:0] disp);
      logic [na-1:0] above;
      logic seen;
      above = '0;
      seen = 1'b0;
      for (int i = 0; i < na; i++) begin
         if (seen) begin
            above[i] = disp[i];
         end
         if (cur[i]) begin
            seen = 1'b1;
         end
      end
      return (above != '0) ? first_of(above) : first_of(disp);
   endfunction : next_axis

   // merge a write into a register under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   // supply sequence: enable raises the bus, start charges then closes the contactor
   function automatic ctrl_marks_pkg::sup_state_t sup_step(input ctrl_marks_pkg::sup_state_t s,
         input logic start, input logic done);
      ctrl_marks_pkg::sup_state_t r;
      r = s;
      case (s)
         ctrl_marks_pkg::sup_off: r = start ? ctrl_marks_pkg::sup_charge : ctrl_marks_pkg::sup_off;
         ctrl_marks_pkg::sup_charge: r = !start ? ctrl_marks_pkg::sup_off
               : (done ? ctrl_marks_pkg::sup_on : ctrl_marks_pkg::sup_charge);
         ctrl_marks_pkg::sup_on: r = start ? ctrl_marks_pkg::sup_on : ctrl_marks_pkg::sup_off;
         default: r = ctrl_marks_pkg::sup_off;
      endcase
      return r;
   endfunction : sup_step

   logic wr_fire;
   logic rd_fire;
   logic [31:0] wr_val;
   logic [31:0] rd_val;
   logic rd_ok;
   logic wr_ok;
   logic [nc-1:0] launch;
   logic probe_cmd;
   logic scan;
   logic ctl_reset;
   logic adv;
   logic jog_hw;
   logic [nc-1:0] abort_mark;
   logic [nc-1:0] prg_abort;

   // next-state logic: bus slave, mark decode, sequences
   always_comb begin
      next_st = st;
      wr_fire = st.aw_full && st.w_full && !st.bvalid;
      rd_fire = s_axi_arvalid && !st.rvalid;
      wr_val = merge(32'h0000_0000, st.w_data, st.w_strb);
      launch = '0;
      probe_cmd = 1'b0;
      scan = 1'b0;
      ctl_reset = 1'b0;
      wr_ok = 1'b1;
      // write channels taken in either order
      if (s_axi_awvalid && !st.aw_full) begin
         next_st.aw_full = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st.w_full) begin
         next_st.w_full = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (wr_fire) begin
         next_st.aw_full = 1'b0;
         next_st.w_full = 1'b0;
         next_st.bvalid = 1'b1;
         case (st.aw_addr)
            ctrl_marks_pkg::reg_chan_marks:
               next_st.chan_marks = 16'(merge({16'h0000, st.chan_marks}, st.w_data, st.w_strb));
            ctrl_marks_pkg::reg_general: begin
               next_st.general = merge(st.general, st.w_data, st.w_strb);
               next_st.general[ctrl_marks_pkg::f_reset] = 1'b0;
               ctl_reset = wr_val[ctrl_marks_pkg::f_reset];
            end
            ctrl_marks_pkg::reg_panel_kbd:
               next_st.panel_kbd = 16'(merge({16'h0000, st.panel_kbd}, st.w_data, st.w_strb));
            ctrl_marks_pkg::reg_sensor:
               next_st.sensor = 20'(merge({12'h000, st.sensor}, st.w_data, st.w_strb));
            ctrl_marks_pkg::reg_axis_disp:
               next_st.axis_disp = na'(merge(32'(st.axis_disp), st.w_data, st.w_strb));
            ctrl_marks_pkg::reg_events: begin
               launch = wr_val[ctrl_marks_pkg::e_launch_base +: nc];
               probe_cmd = wr_val[ctrl_marks_pkg::e_probe_cmd];
               scan = wr_val[ctrl_marks_pkg::e_scan];
            end
            ctrl_marks_pkg::reg_status: begin
               // write one to clear the error flags
               next_st.logic_stop_error = st.logic_stop_error && !wr_val[0];
               next_st.probing_error = st.probing_error && !wr_val[1];
            end
            default: wr_ok = 1'b0;
         endcase
         next_st.bresp = wr_ok ? ctrl_marks_pkg::resp_okay : ctrl_marks_pkg::resp_slverr;
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end
      // register reads
      rd_ok = 1'b1;
      case (s_axi_araddr)
         ctrl_marks_pkg::reg_chan_marks: rd_val = {16'h0000, st.chan_marks};
         ctrl_marks_pkg::reg_general: rd_val = st.general;
         ctrl_marks_pkg::reg_panel_kbd: rd_val = {8'h00, st.kbd_applied, st.panel_kbd};
         ctrl_marks_pkg::reg_sensor: rd_val = {12'h000, st.sensor};
         ctrl_marks_pkg::reg_axis_disp: rd_val = 32'(st.axis_disp);
         ctrl_marks_pkg::reg_events: rd_val = 32'h0000_0000;
         ctrl_marks_pkg::reg_status: rd_val = {12'h000, st.sup2, st.sup1, 8'(st.hw_axis), 6'h00,
               st.probing_error, st.logic_stop_error};
         ctrl_marks_pkg::reg_chan_status: rd_val = {16'h0000, st.prg_restart, st.cmd_aborted,
               st.cmd_busy, st.chan_free};
         default: begin
            rd_val = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
      if (rd_fire) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rd_val;
         next_st.rresp = rd_ok ? ctrl_marks_pkg::resp_okay : ctrl_marks_pkg::resp_slverr;
      end else if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end

      // handwheel axis stepping, sampled once per controller scan
      adv = st.general[ctrl_marks_pkg::f_axis_adv];
      jog_hw = st.general[ctrl_marks_pkg::f_jog_hw];
      if (scan) begin
         next_st.adv_prev = adv;
         next_st.jog_hw_prev = jog_hw;
         if (adv && !st.adv_prev && jog_hw) begin
            next_st.hw_axis = (st.hw_axis & st.axis_disp) == '0 ? first_of(st.axis_disp)
                  : next_axis(st.hw_axis, st.axis_disp);
         end
         if (!jog_hw && st.jog_hw_prev) begin
            next_st.hw_axis = '0;
         end
      end

      // launched command abort and program abort per channel
      abort_mark = st.general[ctrl_marks_pkg::f_abort_base +: nc];
      prg_abort = st.general[ctrl_marks_pkg::f_prg_abort_base +: nc];
      next_st.cmd_aborted = '0;
      next_st.prg_restart = '0;
      for (int c = 0; c < nc; c++) begin
         if (launch[c]) begin
            next_st.cmd_busy[c] = 1'b1;
            next_st.chan_free[c] = 1'b0;
         end
         // a pending mark catches the next launch at once; history untouched
         if (abort_mark[c] && (st.cmd_busy[c] || launch[c])) begin
            next_st.cmd_busy[c] = 1'b0;
            next_st.chan_free[c] = 1'b1;
            next_st.general[ctrl_marks_pkg::f_abort_base + c] = 1'b0;
            next_st.cmd_aborted[c] = 1'b1;
         end
         if (scan) begin
            next_st.prg_abort_prev[c] = prg_abort[c];
            next_st.prg_restart[c] = prg_abort[c] && !st.prg_abort_prev[c]
                  && st.general[ctrl_marks_pkg::f_abort_label_base + c];
         end
      end

      // logic running flag and probing check
      next_st.running_prev = st.general[ctrl_marks_pkg::f_running];
      if (st.running_prev && !st.general[ctrl_marks_pkg::f_running]) begin
         next_st.logic_stop_error = 1'b1;
      end
      if (probe_cmd && !(st.general[ctrl_marks_pkg::f_probe_sel] ? st.general[ctrl_marks_pkg::f_probe2_en]
            : st.general[ctrl_marks_pkg::f_probe1_en])) begin
         next_st.probing_error = 1'b1;
      end

      // supply start sequences
      next_st.sup1 = sup_step(st.sup1, st.general[ctrl_marks_pkg::f_sup1_start], st.cnt1 >= charge_cycles - 1);
      next_st.sup2 = sup_step(st.sup2, st.general[ctrl_marks_pkg::f_sup2_start], st.cnt2 >= charge_cycles - 1);
      next_st.cnt1 = (st.sup1 == ctrl_marks_pkg::sup_charge) ? st.cnt1 + 32'h1 : 32'h0;
      next_st.cnt2 = (st.sup2 == ctrl_marks_pkg::sup_charge) ? st.cnt2 + 32'h1 : 32'h0;

      // keyboard disables take effect after a settle delay
      if (st.panel_kbd[15:8] != st.kbd_applied) begin
         next_st.kbd_cnt = st.kbd_cnt + 32'h1;
         if (st.kbd_cnt >= kbd_delay_cycles - 1) begin
            next_st.kbd_applied = st.panel_kbd[15:8];
            next_st.kbd_cnt = 32'h0;
         end
      end else begin
         next_st.kbd_cnt = 32'h0;
      end

      // channel outputs, one nibble per channel
      for (int c = 0; c < nc; c++) begin
         next_st.chan_out.opt_stop_honour[c] = st.chan_marks[4*c + ctrl_marks_pkg::f_opt_stop];
         next_st.chan_out.jog_rapid[c] = st.chan_marks[4*c + ctrl_marks_pkg::f_rapid];
         next_st.chan_out.wait_release[c] = st.chan_marks[4*c + ctrl_marks_pkg::f_wait_cancel];
         next_st.chan_out.override_full[c] = st.chan_marks[4*c + ctrl_marks_pkg::f_ovr_full];
      end
      next_st.chan_out.chan_free = next_st.chan_free;
      next_st.chan_out.cmd_aborted = next_st.cmd_aborted;
      next_st.chan_out.prg_restart = next_st.prg_restart;
      next_st.gen_out.motion_enable = st.general[ctrl_marks_pkg::f_running];
      next_st.gen_out.logic_stop_error = next_st.logic_stop_error;
      next_st.gen_out.probing_error = next_st.probing_error;
      next_st.gen_out.probe_one_safe = st.general[ctrl_marks_pkg::f_probe1_mon];
      next_st.gen_out.probe_two_safe = st.general[ctrl_marks_pkg::f_probe2_mon];
      next_st.gen_out.supply_one_on = st.general[ctrl_marks_pkg::f_sup1_en];
      next_st.gen_out.supply_two_on = st.general[ctrl_marks_pkg::f_sup2_en];
      next_st.gen_out.supply_one_contactor = next_st.sup1 == ctrl_marks_pkg::sup_on;
      next_st.gen_out.supply_two_contactor = next_st.sup2 == ctrl_marks_pkg::sup_on;

      // control reset clears the handwheel selection
      if (ctl_reset) begin
         next_st.hw_axis = '0;
      end
      if (!aresetn) begin
         next_st = '0;
         next_st.general = ctrl_marks_pkg::general_rst;
         next_st.chan_free = '1;
         next_st.chan_out.chan_free = '1;
         next_st.sup1 = ctrl_marks_pkg::sup_off;
         next_st.sup2 = ctrl_marks_pkg::sup_off;
      end
   end

   // single state register, synchronous reset folded in above
   always_ff @(posedge aclk) begin
      st <= next_st;
   end

   // outputs straight from state flops
   assign s_axi_awready = !st.aw_full;
   assign s_axi_wready = !st.w_full;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign chan_out = st.chan_out;
   assign gen_out = st.gen_out;
   assign handwheel_axis = st.hw_axis;
   assign panel_off = st.panel_kbd[7:0];
   assign keyboard_off = st.kbd_applied;
   assign sensor_off = st.sensor;
endmodule : ctrl_marks

//--- dv/ctrl_marks_chk.sv
// port-level assertions for the control-mark block
`timescale 1ns/1ps
module ctrl_marks_chk #(
   parameter int unsigned charge_cycles = 4,
   parameter int unsigned kbd_delay_cycles = 8
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus answers
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   // decoded controls
   input wire ctrl_marks_pkg::chan_out_t chan_out,
   input wire ctrl_marks_pkg::gen_out_t gen_out,
   input wire logic [ctrl_marks_pkg::num_axis-1:0] handwheel_axis
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [2:0] wr_hist;
   // recent write answers: the handwheel axis may only move, and the probing error flag only clear, shortly after one, never on their own
   always_ff @(posedge aclk) begin
      wr_hist <= aresetn ? {wr_hist[1:0], s_axi_bvalid} : 3'h0;
   end
   sequence rd_wait_s; s_axi_rvalid && !s_axi_rready; endsequence
   sequence wr_wait_s; s_axi_bvalid && !s_axi_bready; endsequence
   sequence run_drop_s; $fell(gen_out.motion_enable); endsequence
   b_hold_a: assert property (wr_wait_s |=> s_axi_bvalid) else $error("write answer dropped early");
   r_hold_a: assert property (rd_wait_s |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
   r_single_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answered twice");
   axis_onehot_a: assert property ($onehot0(handwheel_axis)) else $error("several axes selected");
   // the state moves on the edge that raises the write answer, so the live answer counts too
   axis_quiet_a: assert property ($changed(handwheel_axis) |-> |wr_hist || s_axi_bvalid) else $error("axis moved unasked");
   abort_pulse_a: assert property (|chan_out.cmd_aborted |=> ~|chan_out.cmd_aborted) else $error("abort held");
   stop_err_a: assert property (run_drop_s |-> ##[0:2] gen_out.logic_stop_error) else $error("no stop error");
   probe_err_a: assert property ($fell(gen_out.probing_error) |-> |wr_hist || s_axi_bvalid) else $error("error lost");
endmodule : ctrl_marks_chk

bind ctrl_marks ctrl_marks_chk #(.charge_cycles(charge_cycles), .kbd_delay_cycles(kbd_delay_cycles)) chk_u (
   .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .chan_out(chan_out), .gen_out(gen_out), .handwheel_axis(handwheel_axis)
);

//--- dv/plc_master.sv
// logic controller model: writes and reads control marks as bus master
`timescale 1ns/1ps
module plc_master (
   // clock
   input wire logic aclk,
   // write side
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // read side
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   logic [1:0] resp;
   logic [31:0] data;
   // idle bus; full words only, so each write rewrites every mark of the register it hits
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
   end
   // released data is inverted so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wdata <= ~d;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      do @(posedge aclk); while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : plc_master

//--- dv/plc_to_cnc_control_marks_tb.sv
// self-checking bench for the control-mark block
`timescale 1ns/1ps
module plc_to_cnc_control_marks_tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, handwheel_axis, panel_off, keyboard_off;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [19:0] sensor_off;
   ctrl_marks_pkg::chan_out_t chan_out;
   ctrl_marks_pkg::gen_out_t gen_out;
   int fails = 0;
   int cmp_count = 0;
   int cycles = 0;
   int aborts = 0;
   int restarts = 0;
   localparam logic [7:0] gen = ctrl_marks_pkg::reg_general;
   localparam logic [7:0] evt = ctrl_marks_pkg::reg_events;
   // short counts keep the charge and keyboard waits within a few cycles
   ctrl_marks #(.charge_cycles(4), .kbd_delay_cycles(8)) dut_u (.*);
   plc_master bus_u (.*);
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // timeout, and counts of the one-cycle abort and restart pulses of channel one
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (chan_out.cmd_aborted[0] === 1'b1) aborts <= aborts + 1;
      if (chan_out.prg_restart[0] === 1'b1) restarts <= restarts + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         finish_test();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic settle;
      repeat (4) @(posedge aclk);
   endtask : settle
   task automatic scan(input logic [31:0] g);
      bus_u.wr(gen, g);
      bus_u.wr(evt, 32'h20);
      settle();
   endtask : scan
   task automatic t_reset;
      chk("free", chan_out.chan_free, 4'hf);
      bus_u.rd(gen);
      chk("general", bus_u.data, ctrl_marks_pkg::general_rst);
      bus_u.rd(8'h20);
      chk("rd unmapped", bus_u.resp, ctrl_marks_pkg::resp_slverr);
      bus_u.wr(8'h20, 32'hffff_ffff);
      chk("wr unmapped", bus_u.resp, ctrl_marks_pkg::resp_slverr);
   endtask : t_reset
   task automatic t_chan;
      bus_u.wr(ctrl_marks_pkg::reg_chan_marks, 32'h0000_8421);
      settle();
      chk("opt stop", chan_out.opt_stop_honour, 4'h1);
      chk("rapid", chan_out.jog_rapid, 4'h2);
      chk("wait", chan_out.wait_release, 4'h4);
      chk("override", chan_out.override_full, 4'h8);
   endtask : t_chan
   task automatic t_panel;
      bus_u.wr(ctrl_marks_pkg::reg_panel_kbd, 32'h0000_8001);
      settle();
      chk("panel", panel_off, 8'h01);
      chk("kbd early", keyboard_off, 8'h00);
      bus_u.wr(ctrl_marks_pkg::reg_sensor, 32'h0008_0001);
      repeat (12) @(posedge aclk);
      chk("kbd", keyboard_off, 8'h80);
      chk("sensor", sensor_off, 20'h80001);
   endtask : t_panel
   task automatic t_supply;
      bus_u.wr(gen, 32'h0000_01e7);
      settle();
      chk("motion", gen_out.motion_enable, 1'b1);
      chk("sup", {gen_out.supply_one_on, gen_out.supply_two_on}, 2'b11);
      repeat (20) @(posedge aclk);
      chk("contactor", {gen_out.supply_one_contactor, gen_out.supply_two_contactor}, 2'b11);
      bus_u.wr(gen, 32'h0000_00a7);
      settle();
      chk("drop", {gen_out.supply_one_contactor, gen_out.supply_two_contactor}, 2'b00);
      bus_u.wr(gen, 32'h0000_0006);
      settle();
      chk("stopped", {gen_out.motion_enable, gen_out.logic_stop_error}, 2'b01);
      chk("sup off", {gen_out.supply_one_on, gen_out.supply_two_on}, 2'b00);
   endtask : t_supply
   task automatic t_probe;
      bus_u.wr(gen, 32'h0000_001c);
      bus_u.wr(evt, 32'h10);
      settle();
      chk("safe", {gen_out.probe_one_safe, gen_out.probe_two_safe}, 2'b11);
      chk("probe err", gen_out.probing_error, 1'b1);
      bus_u.wr(ctrl_marks_pkg::reg_status, 32'h3);
      bus_u.wr(gen, 32'h0000_081c);
      bus_u.wr(evt, 32'h10);
      settle();
      chk("probe ok", gen_out.probing_error, 1'b0);
   endtask : t_probe
   task automatic t_abort;
      int n;
      bus_u.wr(gen, 32'h0001_0006);
      bus_u.rd(gen);
      chk("pending", bus_u.data[16], 1'b1);
      n = aborts;
      bus_u.wr(evt, 32'h1);
      settle();
      chk("aborted", aborts - n, 1);
      bus_u.rd(gen);
      chk("mark off", bus_u.data[16], 1'b0);
      chk("free", chan_out.chan_free[0], 1'b1);
      n = aborts;
      bus_u.wr(evt, 32'h1);
      settle();
      chk("no abort", aborts - n, 0);
   endtask : t_abort
   task automatic t_prg;
      int n;
      n = restarts;
      scan(32'h0100_0006);
      scan(32'h0110_0006);
      chk("restart", restarts - n, 1);
      scan(32'h0000_0006);
      scan(32'h0010_0006);
      chk("no label", restarts - n, 1);
   endtask : t_prg
   task automatic t_hand;
      logic [7:0] exp_axis [3] = '{8'h04, 8'h20, 8'h04};
      bus_u.wr(ctrl_marks_pkg::reg_axis_disp, 32'h24);
      for (int i = 0; i < 3; i++) begin
         scan(32'h206);
         scan(32'h606);
         chk("axis", handwheel_axis, exp_axis[i]);
      end
      scan(32'h606);
      chk("held", handwheel_axis, 8'h04);
      scan(32'h006);
      chk("left", handwheel_axis, 8'h00);
      scan(32'h406);
      chk("not jog", handwheel_axis, 8'h00);
      scan(32'h206);
      scan(32'h606);
      chk("reselect", handwheel_axis, 8'h04);
      bus_u.wr(gen, 32'h1606);
      settle();
      chk("ctl reset", handwheel_axis, 8'h00);
   endtask : t_hand
   task automatic finish_test;
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   initial begin
      aresetn = 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_chan();
      t_panel();
      t_supply();
      t_probe();
      t_abort();
      t_prg();
      t_hand();
      finish_test();
   end
endmodule : plc_to_cnc_control_marks_tb
